// [core/psu_pkg.sv]
// Shared constants, carriers and state codes of the power supply fault supervisor.
// Assumes a 40 MHz controller clock; all timing counts derive from CLK_KHZ.
package psu_pkg;

    // ********************************************
    // Clock and timing
    // ********************************************
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned TIMER_W = 32;
    localparam int unsigned OCP_QUAL_MS = 100;
    localparam int unsigned OCW_QUAL_MS = 12;
    localparam int unsigned AUX_OC_QUAL_MS = 10;
    localparam int unsigned HICCUP_OFF_MS = 100;
    localparam int unsigned OPP_QUAL_MS = 2;
    localparam int unsigned ONREQ_HIGH_CLEAR_MS = 1000;
    localparam int unsigned AC_OFF_CLEAR_MS = 15000;

    // ********************************************
    // Serial bus targets
    // ********************************************
    localparam logic [7:0] FIELD_INFO_BASE = 8'ha0;
    localparam logic [7:0] SUPPLY_MGMT_BASE = 8'hb0;
    localparam logic [7:0] FIELD_INFO_FILL = 8'hff;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ********************************************
    // Carriers
    // ********************************************
    typedef struct packed {
        logic overcurrentTrip;
        logic overcurrentWarning;
        logic standbyOvercurrentTrip;
        logic overvoltageTrip;
        logic auxOvervoltage;
        logic shortCircuitTrip;
        logic auxShortCircuit;
        logic overPowerTrip;
        logic overTempHigh;
        logic overTempRecovered;
        logic tempWarning;
        logic acLost;
        logic undervoltage;
        logic fanFail;
        logic generalFailure;
        logic voutInReg;
    } fault_in_s;

    localparam int unsigned FAULT_W = $bits(fault_in_s);

    typedef struct packed {
        logic mainLatched;
        logic otActive;
        logic auxOff;
        logic acLost;
        logic warning;
        logic critical;
        logic powerGood;
        logic mainOn;
    } status_s;

    localparam status_s STATUS_RESET = 8'h00;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_ADDR_ACK = 3'b010,
        I2C_TX = 3'b011,
        I2C_TX_ACK = 3'b100,
        I2C_RX = 3'b101,
        I2C_RX_ACK = 3'b110
    } i2c_state_e;

endpackage : psu_pkg

// [core/sync3.sv]
// Three flip-flop synchroniser for a group of bits from another domain.
// Output follows once the second and third stages agree.
`timescale 1ns/1ps
module sync3 #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s syncReg;
    sync_s syncNext;

    always_comb begin
        syncNext = syncReg;
        syncNext.s1 = din;
        syncNext.s2 = syncReg.s1;
        syncNext.s3 = syncReg.s2;
        for (int i = 0; i < W; i++) begin
            if (syncReg.s2[i] == syncReg.s3[i]) begin
                syncNext.q[i] = syncReg.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncReg <= '0;
        end else begin
            syncReg <= syncNext;
        end
    end

    assign dout = syncReg.q;
endmodule : sync3

// [core/qual_timer.sv]
// Qualification timer: done rises once cond has held for limit cycles.
// Assumes limit of at least one; any drop of cond restarts the count.
`timescale 1ns/1ps
module qual_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cond,
    input wire logic [psu_pkg::TIMER_W-1:0] limit,
    output logic done
);
    import psu_pkg::*;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
        logic done;
    } timer_s;

    timer_s timerReg;
    timer_s timerNext;

    always_comb begin
        timerNext = timerReg;
        if (!cond) begin
            timerNext.count = '0;
        end else if (timerReg.count < limit) begin
            timerNext.count = timerReg.count + 1'b1;
        end
        timerNext.done = cond && (timerNext.count >= limit);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerReg <= '0;
        end else begin
            timerReg <= timerNext;
        end
    end

    assign done = timerReg.done;
endmodule : qual_timer

// [core/psu_fault_supervisor.sv]
// Fault supervisor of the power module: protection latches, standby hiccup,
// alert and status indication, and the slave side of the management serial bus.
// Assumes comparator fault levels and straps arrive as asynchronous pins, and that
// the serial bus logic runs on its own link clock, unrelated to clk.
`timescale 1ns/1ps

// What this block does
// - Trips shut only main output, standby separate
// - Latch cleared by long AC off or request high
// - Sustained overcurrent latches off after qualification
// - Sustained overcurrent warning alerts, no shutdown
// - Standby overcurrent gives hiccup retry shutdown
// - Overvoltage shuts down and latches
// - Standby restarts itself when fault clears
// - Overtemperature shuts main, auto restores later
// - Overtemperature recovery uses separate lower threshold
// - Current limit exceeded latches main off
// - Shorted main output latches off
// - Short over-power bursts do not trip
// - Alert raised before over-power trip
// - Temperature warning alerts, keeps running
// - AC loss raises alert within four ms
// - Straps select bus target addresses
// - Bus logic acts only as slave
// - Alert active low for warnings and faults
// - Alert and amber indicator change together
// - Active low request enables main output
// - Power good drops quickly after request release
module psu_fault_supervisor #(
    parameter int unsigned OCP_QUAL_CYC = psu_pkg::OCP_QUAL_MS * psu_pkg::CLK_KHZ,
    parameter int unsigned OCW_QUAL_CYC = psu_pkg::OCW_QUAL_MS * psu_pkg::CLK_KHZ,
    parameter int unsigned AUX_OC_QUAL_CYC = psu_pkg::AUX_OC_QUAL_MS * psu_pkg::CLK_KHZ,
    parameter int unsigned HICCUP_OFF_CYC = psu_pkg::HICCUP_OFF_MS * psu_pkg::CLK_KHZ,
    parameter int unsigned OPP_QUAL_CYC = psu_pkg::OPP_QUAL_MS * psu_pkg::CLK_KHZ,
    parameter int unsigned ONREQ_HIGH_CYC = psu_pkg::ONREQ_HIGH_CLEAR_MS * psu_pkg::CLK_KHZ,
    parameter int unsigned AC_OFF_CYC = psu_pkg::AC_OFF_CLEAR_MS * psu_pkg::CLK_KHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire psu_pkg::fault_in_s faultIn,
    input wire logic onReq_n,
    input wire logic slotAddrBit0,
    input wire logic slotAddrBit1,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic mainEnable,
    output logic auxEnable,
    output logic powerGood,
    output logic alertOut,
    output logic alertOe_n,
    output logic ledAmberSolid,
    output logic ledAmberBlink,
    output logic sdaOut,
    output logic sdaOe_n,
    output psu_pkg::status_s statusOut
);
    import psu_pkg::*;

    // ********************************************
    // State of both domains
    // ********************************************
    typedef struct packed {
        logic mainLatched;
        logic otActive;
        logic armed;
        logic hiccup;
        logic mainOn;
        logic auxOn;
        logic powerGood;
        logic alertOe_n;
        logic ledSolid;
        logic ledBlink;
        status_s status;
        status_s statusHold;
        logic req;
    } core_s;

    typedef struct packed {
        i2c_state_e state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic rw;
        logic nack;
        logic isMgmt;
        logic sclPrev;
        logic sdaPrev;
        logic sdaOe_n;
        logic sdaOut;
        logic ack;
        status_s statusCopy;
    } link_s;

    core_s coreReg;
    core_s coreNext;
    link_s linkReg;
    link_s linkNext;

    // ********************************************
    // Input synchronisers and qualification timers
    // ********************************************
    fault_in_s f;
    logic onReqActive;
    logic ackSync;
    logic ocpDone;
    logic ocwDone;
    logic auxOcDone;
    logic oppDone;
    logic onReqHighDone;
    logic acOffDone;
    logic hiccupDone;

    // Request enters inverted so that the reset value reads as no request
    sync3 #(.W(FAULT_W + 1)) u_pinSync (.clk(clk), .rst_n(rst_n), .din({faultIn, ~onReq_n}),
        .dout({f, onReqActive}));
    sync3 #(.W(1)) u_ackSync (.clk(clk), .rst_n(rst_n), .din(linkReg.ack), .dout(ackSync));

    qual_timer u_ocpTimer (.clk(clk), .rst_n(rst_n), .cond(f.overcurrentTrip),
        .limit(OCP_QUAL_CYC), .done(ocpDone));
    qual_timer u_ocwTimer (.clk(clk), .rst_n(rst_n), .cond(f.overcurrentWarning),
        .limit(OCW_QUAL_CYC), .done(ocwDone));
    qual_timer u_auxOcTimer (.clk(clk), .rst_n(rst_n), .cond(f.standbyOvercurrentTrip),
        .limit(AUX_OC_QUAL_CYC), .done(auxOcDone));
    qual_timer u_hiccupTimer (.clk(clk), .rst_n(rst_n), .cond(coreReg.hiccup),
        .limit(HICCUP_OFF_CYC), .done(hiccupDone));
    // Excursions shorter than the qualification restart the count
    qual_timer u_oppTimer (.clk(clk), .rst_n(rst_n), .cond(f.overPowerTrip),
        .limit(OPP_QUAL_CYC), .done(oppDone));
    qual_timer u_onReqHighTimer (.clk(clk), .rst_n(rst_n), .cond(!onReqActive),
        .limit(ONREQ_HIGH_CYC), .done(onReqHighDone));
    qual_timer u_acOffTimer (.clk(clk), .rst_n(rst_n), .cond(f.acLost),
        .limit(AC_OFF_CYC), .done(acOffDone));

    // ********************************************
    // Protection, standby and indication
    // ********************************************
    logic latchSet;
    logic warning;
    logic critical;

    always_comb begin
        coreNext = coreReg;
        latchSet = ocpDone | f.overvoltageTrip | f.shortCircuitTrip | oppDone;

        // Request high phase must last long enough before a low clears the latch
        if (onReqHighDone) begin
            coreNext.armed = 1'b1;
        end
        if (coreReg.armed && onReqActive) begin
            coreNext.mainLatched = 1'b0;
            coreNext.armed = 1'b0;
        end
        if (acOffDone) begin
            coreNext.mainLatched = 1'b0;
        end
        // Set wins over any clear in the same cycle
        if (latchSet) begin
            coreNext.mainLatched = 1'b1;
        end

        // Trip above the high threshold, recover only below the lower one
        if (f.overTempHigh) begin
            coreNext.otActive = 1'b1;
        end else if (f.overTempRecovered) begin
            coreNext.otActive = 1'b0;
        end

        if (!coreReg.hiccup && auxOcDone) begin
            coreNext.hiccup = 1'b1;
        end else if (coreReg.hiccup && hiccupDone) begin
            coreNext.hiccup = 1'b0;
        end
        coreNext.auxOn = !coreNext.hiccup && !f.auxOvervoltage && !f.auxShortCircuit;

        // Standby is steered only by its own faults, never by main trips
        coreNext.mainOn = onReqActive && !coreNext.mainLatched && !coreNext.otActive;
        coreNext.powerGood = coreNext.mainOn && f.voutInReg;

        warning = ocwDone | f.tempWarning | f.overPowerTrip | f.acLost | f.undervoltage
            | f.fanFail;
        critical = coreNext.mainLatched | coreNext.otActive | f.generalFailure
            | f.overvoltageTrip | f.overcurrentTrip | f.shortCircuitTrip | coreNext.hiccup
            | f.auxOvervoltage | f.auxShortCircuit;
        coreNext.alertOe_n = !(warning || critical);
        coreNext.ledSolid = critical;
        coreNext.ledBlink = warning && !critical;

        coreNext.status.mainLatched = coreNext.mainLatched;
        coreNext.status.otActive = coreNext.otActive;
        coreNext.status.auxOff = !coreNext.auxOn;
        coreNext.status.acLost = f.acLost;
        coreNext.status.warning = warning;
        coreNext.status.critical = critical;
        coreNext.status.powerGood = coreNext.powerGood;
        coreNext.status.mainOn = coreNext.mainOn;

        // Hold word stays frozen while a transfer to the link is outstanding
        if (coreReg.req == ackSync && coreReg.statusHold != coreReg.status) begin
            coreNext.statusHold = coreReg.status;
            coreNext.req = !coreReg.req;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreReg <= '{alertOe_n: 1'b1, status: STATUS_RESET, statusHold: STATUS_RESET,
                default: 1'b0};
        end else begin
            coreReg <= coreNext;
        end
    end

    // ********************************************
    // Serial bus slave on the link clock
    // ********************************************
    logic scl;
    logic sda;
    logic slot0;
    logic slot1;
    logic reqSync;
    logic sclRise;
    logic sclFall;
    logic [7:0] slotOffset;
    logic [7:0] txByte;

    sync3 #(.W(4)) u_linkPinSync (.clk(linkClk), .rst_n(rst_n),
        .din({sclIn, sdaIn, slotAddrBit0, slotAddrBit1}), .dout({scl, sda, slot0, slot1}));
    sync3 #(.W(1)) u_reqSync (.clk(linkClk), .rst_n(rst_n), .din(coreReg.req), .dout(reqSync));

    always_comb begin
        linkNext = linkReg;
        sclRise = !linkReg.sclPrev && scl;
        sclFall = linkReg.sclPrev && !scl;
        slotOffset = {5'h00, slot1, slot0, 1'b0};
        txByte = linkReg.isMgmt ? linkReg.statusCopy : FIELD_INFO_FILL;
        linkNext.sclPrev = scl;
        linkNext.sdaPrev = sda;
        linkNext.sdaOut = 1'b0;

        if (reqSync != linkReg.ack) begin
            linkNext.statusCopy = coreReg.statusHold;
            linkNext.ack = reqSync;
        end

        // The slave never drives the clock; it only pulls data low
        unique case (linkReg.state)
            I2C_IDLE: begin
                linkNext.sdaOe_n = 1'b1;
            end
            I2C_ADDR: begin
                if (sclRise) begin
                    linkNext.shift = {linkReg.shift[6:0], sda};
                    linkNext.bitCnt = linkReg.bitCnt + 4'h1;
                end else if (sclFall && linkReg.bitCnt == BITS_PER_BYTE) begin
                    if (linkReg.shift[7:1] == (FIELD_INFO_BASE[7:1] | slotOffset[7:1])) begin
                        linkNext.isMgmt = 1'b0;
                        linkNext.state = I2C_ADDR_ACK;
                        linkNext.sdaOe_n = 1'b0;
                    end else if (linkReg.shift[7:1]
                        == (SUPPLY_MGMT_BASE[7:1] | slotOffset[7:1])) begin
                        linkNext.isMgmt = 1'b1;
                        linkNext.state = I2C_ADDR_ACK;
                        linkNext.sdaOe_n = 1'b0;
                    end else begin
                        linkNext.state = I2C_IDLE;
                    end
                    linkNext.rw = linkReg.shift[0];
                end
            end
            I2C_ADDR_ACK: begin
                if (sclFall) begin
                    if (linkReg.rw) begin
                        linkNext.sdaOe_n = txByte[7];
                        linkNext.shift = {txByte[6:0], 1'b0};
                        linkNext.bitCnt = 4'h1;
                        linkNext.state = I2C_TX;
                    end else begin
                        linkNext.sdaOe_n = 1'b1;
                        linkNext.bitCnt = 4'h0;
                        linkNext.state = I2C_RX;
                    end
                end
            end
            I2C_TX: begin
                if (sclFall) begin
                    if (linkReg.bitCnt == BITS_PER_BYTE) begin
                        linkNext.sdaOe_n = 1'b1;
                        linkNext.state = I2C_TX_ACK;
                    end else begin
                        linkNext.sdaOe_n = linkReg.shift[7];
                        linkNext.shift = {linkReg.shift[6:0], 1'b0};
                        linkNext.bitCnt = linkReg.bitCnt + 4'h1;
                    end
                end
            end
            I2C_TX_ACK: begin
                if (sclRise) begin
                    linkNext.nack = sda;
                end else if (sclFall) begin
                    if (linkReg.nack) begin
                        linkNext.state = I2C_IDLE;
                    end else begin
                        linkNext.sdaOe_n = txByte[7];
                        linkNext.shift = {txByte[6:0], 1'b0};
                        linkNext.bitCnt = 4'h1;
                        linkNext.state = I2C_TX;
                    end
                end
            end
            I2C_RX: begin
                if (sclRise) begin
                    linkNext.shift = {linkReg.shift[6:0], sda};
                    linkNext.bitCnt = linkReg.bitCnt + 4'h1;
                end else if (sclFall && linkReg.bitCnt == BITS_PER_BYTE) begin
                    linkNext.sdaOe_n = 1'b0;
                    linkNext.state = I2C_RX_ACK;
                end
            end
            I2C_RX_ACK: begin
                if (sclFall) begin
                    linkNext.sdaOe_n = 1'b1;
                    linkNext.bitCnt = 4'h0;
                    linkNext.state = I2C_RX;
                end
            end
            default: begin
                linkNext.state = I2C_IDLE;
                linkNext.sdaOe_n = 1'b1;
            end
        endcase

        // Start and stop override any bit in progress
        if (linkReg.sclPrev && scl && linkReg.sdaPrev && !sda) begin
            linkNext.state = I2C_ADDR;
            linkNext.bitCnt = 4'h0;
            linkNext.sdaOe_n = 1'b1;
        end else if (linkReg.sclPrev && scl && !linkReg.sdaPrev && sda) begin
            linkNext.state = I2C_IDLE;
            linkNext.sdaOe_n = 1'b1;
        end
    end

    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            linkReg <= '{state: I2C_IDLE, bitCnt: 4'h0, shift: 8'h00, rw: 1'b0, nack: 1'b0,
                isMgmt: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1, sdaOe_n: 1'b1, sdaOut: 1'b0,
                ack: 1'b0, statusCopy: STATUS_RESET};
        end else begin
            linkReg <= linkNext;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign mainEnable = coreReg.mainOn;
    assign auxEnable = coreReg.auxOn;
    assign powerGood = coreReg.powerGood;
    assign alertOut = 1'b0;
    assign alertOe_n = coreReg.alertOe_n;
    assign ledAmberSolid = coreReg.ledSolid;
    assign ledAmberBlink = coreReg.ledBlink;
    assign statusOut = coreReg.status;
    assign sdaOut = linkReg.sdaOut;
    assign sdaOe_n = linkReg.sdaOe_n;
endmodule : psu_fault_supervisor

// [sim/psu_fault_supervisor_properties.sv]
// Concurrent checks on the ports of the fault supervisor, bound into it.
// Assumes the controller clock domain and its active low async reset.
`timescale 1ns/1ps
module psu_fault_supervisor_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire psu_pkg::fault_in_s faultIn,
    input wire logic onReq_n,
    input wire logic mainEnable,
    input wire logic auxEnable,
    input wire logic powerGood,
    input wire logic alertOe_n,
    input wire logic ledAmberSolid,
    input wire logic ledAmberBlink,
    input wire psu_pkg::status_s statusOut
);
    import psu_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Protection and alert
    // ****************************************
    latch_off_a: assert property (statusOut.mainLatched |-> !mainEnable)
        else $error("main on while latched");
    temp_off_a: assert property (statusOut.otActive |-> !mainEnable)
        else $error("main on while hot");
    req_off_a: assert property (onReq_n [*8] |-> !mainEnable)
        else $error("main on without request");
    good_follow_a: assert property (powerGood |-> mainEnable)
        else $error("power good without main");
    alert_led_a: assert property ((!alertOe_n) == (ledAmberSolid || ledAmberBlink))
        else $error("alert and amber disagree");
    latch_alert_a: assert property (statusOut.mainLatched |-> ledAmberSolid && !alertOe_n)
        else $error("latched without alert");
    ac_alert_a: assert property (faultIn.acLost [*8] |-> !alertOe_n)
        else $error("ac loss without alert");
    aux_keep_a: assert property ($fell(mainEnable) && $past(auxEnable) |-> auxEnable)
        else $error("standby dropped with main");
    alert_free_a: assert property ($rose(alertOe_n) |-> !statusOut.warning && !statusOut.critical)
        else $error("alert released early");
endmodule : psu_fault_supervisor_properties

bind psu_fault_supervisor psu_fault_supervisor_properties u_psu_fault_supervisor_properties (
    .clk(clk), .rst_n(rst_n), .faultIn(faultIn), .onReq_n(onReq_n), .mainEnable(mainEnable),
    .auxEnable(auxEnable), .powerGood(powerGood), .alertOe_n(alertOe_n),
    .ledAmberSolid(ledAmberSolid), .ledAmberBlink(ledAmberBlink), .statusOut(statusOut));

// [sim/i2c_host_model.sv]
// Management controller model: serial bus master reading one byte.
// Assumes pull-ups on both lines; the clock line idles high between frames.
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic sdaOe_n,
    input wire logic sdaOut,
    output logic sclLine,
    output logic sdaLine
);
    logic drive = 1'b1;
    assign sdaLine = drive & (sdaOe_n | sdaOut);
    initial sclLine = 1'b1;
    // 100 kHz bit: data moves only while the clock is low
    task automatic send_bit(input logic b, output logic r);
        drive = b;
        #2500 sclLine = 1'b1;
        #2500 r = sdaLine;
        #2500 sclLine = 1'b0;
        #2500;
    endtask : send_bit
    task automatic read(input logic [7:0] addr, output logic ack, output logic [7:0] data);
        logic r;
        data = 8'h00;
        drive = 1'b0;
        #5000 sclLine = 1'b0;
        #2500;
        for (int i = 7; i >= 0; i--) begin
            send_bit(addr[i], r);
        end
        send_bit(1'b1, r);
        ack = ~r;
        if (ack) begin
            for (int i = 7; i >= 0; i--) begin
                send_bit(1'b1, data[i]);
            end
            send_bit(1'b1, r);
        end
        drive = 1'b0;
        #2500 sclLine = 1'b1;
        #2500 drive = 1'b1;
    endtask : read
endmodule : i2c_host_model

// [sim/psu_fault_supervisor_test.sv]
// Self-checking bench of the fault supervisor with a bus host model.
// Assumes shortened counts and a free running 32 ns link clock.
`timescale 1ns/1ps
module psu_fault_supervisor_test;
    import psu_pkg::*;
    localparam int OVERCURRENT_TRIP = 400, OVERCURRENT_WARNING = 100, AUX = 50, HIC = 200, OVER_POWER_TRIP = 80, REQ = 300, AC = 500;
    localparam int SET = 8;
    logic clk = 0, linkClk = 0, rst_n = 0, onReq_n = 1, ack, slot0 = 1;
    fault_in_s faultIn = '0;
    logic sclLine, sdaLine, mainEnable, auxEnable, powerGood, alertOut, alertOe_n;
    logic ledAmberSolid, ledAmberBlink, sdaOut, sdaOe_n;
    logic [7:0] rd;
    status_s statusOut;
    int failures = 0, comparisons = 0, cycles = 0;
    initial forever #12.5 clk = ~clk;
    initial begin
        #7;
        forever #16 linkClk = ~linkClk;
    end
    psu_fault_supervisor #(.OCP_QUAL_CYC(OVERCURRENT_TRIP), .OCW_QUAL_CYC(OVERCURRENT_WARNING), .AUX_OC_QUAL_CYC(AUX),
        .HICCUP_OFF_CYC(HIC), .OPP_QUAL_CYC(OVER_POWER_TRIP), .ONREQ_HIGH_CYC(REQ), .AC_OFF_CYC(AC))
    u_psu_fault_supervisor (.clk(clk), .rst_n(rst_n), .linkClk(linkClk), .faultIn(faultIn),
        .onReq_n(onReq_n), .slotAddrBit0(slot0), .slotAddrBit1(1'b0), .sclIn(sclLine),
        .sdaIn(sdaLine), .mainEnable(mainEnable), .auxEnable(auxEnable),
        .powerGood(powerGood), .alertOut(alertOut), .alertOe_n(alertOe_n),
        .ledAmberSolid(ledAmberSolid), .ledAmberBlink(ledAmberBlink), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .statusOut(statusOut));
    i2c_host_model u_i2c_host_model (.sdaOe_n(sdaOe_n), .sdaOut(sdaOut), .sclLine(sclLine),
        .sdaLine(sdaLine));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cycle_req;
        onReq_n = 1'b1;
        tick(REQ + 10);
        chk("good", powerGood, 0);
        onReq_n = 1'b0;
        tick(SET);
    endtask : cycle_req
    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            stop_test();
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_latches;
        faultIn.overvoltageTrip = 1'b1;
        tick(SET);
        chk("main", mainEnable, 0);
        chk("aux", auxEnable, 1);
        chk("solid", ledAmberSolid, 1);
        faultIn.overvoltageTrip = 1'b0;
        onReq_n = 1'b1;
        tick(100);
        onReq_n = 1'b0;
        tick(SET);
        chk("main", mainEnable, 0);
        cycle_req();
        chk("main", mainEnable, 1);
        chk("alert", alertOe_n, 1);
        faultIn.shortCircuitTrip = 1'b1;
        tick(SET);
        chk("main", mainEnable, 0);
        faultIn.shortCircuitTrip = 1'b0;
        cycle_req();
        chk("main", mainEnable, 1);
        $display("latches done");
    endtask : t_latches
    task automatic t_overcurrent;
        faultIn.overcurrentTrip = 1'b1;
        tick(OVERCURRENT_TRIP - 20);
        chk("main", mainEnable, 1);
        tick(30);
        chk("latch", statusOut.mainLatched, 1);
        faultIn.overcurrentTrip = 1'b0;
        faultIn.acLost = 1'b1;
        tick(SET);
        chk("alert", alertOe_n, 0);
        tick(AC + 10);
        faultIn.acLost = 1'b0;
        tick(SET);
        chk("main", mainEnable, 1);
        $display("overcurrent done");
    endtask : t_overcurrent
    task automatic t_temp_aux;
        faultIn.overTempHigh = 1'b1;
        tick(SET);
        chk("main", mainEnable, 0);
        faultIn.overTempHigh = 1'b0;
        tick(SET);
        chk("main", mainEnable, 0);
        faultIn.overTempRecovered = 1'b1;
        tick(SET);
        chk("main", mainEnable, 1);
        faultIn.overTempRecovered = 1'b0;
        faultIn.standbyOvercurrentTrip = 1'b1;
        tick(AUX + SET);
        chk("aux", auxEnable, 0);
        chk("main", mainEnable, 1);
        faultIn.standbyOvercurrentTrip = 1'b0;
        tick(HIC + SET);
        chk("aux", auxEnable, 1);
        $display("temp aux done");
    endtask : t_temp_aux
    task automatic t_warnings;
        repeat (3) begin
            faultIn.overPowerTrip = 1'b1;
            tick(OVER_POWER_TRIP - 20);
            chk("alert", alertOe_n, 0);
            faultIn.overPowerTrip = 1'b0;
            tick(SET);
        end
        chk("main", mainEnable, 1);
        faultIn.overcurrentWarning = 1'b1;
        tick(OVERCURRENT_WARNING - 20);
        chk("alert", alertOe_n, 1);
        tick(30);
        chk("blink", ledAmberBlink, 1);
        chk("main", mainEnable, 1);
        faultIn.overcurrentWarning = 1'b0;
        faultIn.tempWarning = 1'b1;
        tick(SET);
        chk("alert", alertOe_n, 0);
        chk("alert pin", alertOut, 0);
        faultIn.tempWarning = 1'b0;
        tick(SET);
        chk("alert", alertOe_n, 1);
        $display("warnings done");
    endtask : t_warnings
    task automatic t_bus;
        u_i2c_host_model.read(8'hb3, ack, rd);
        chk("ack", ack, 1);
        chk("status", rd, 8'h03);
        #1000000;
        slot0 = 1'b0;
        u_i2c_host_model.read(8'hb3, ack, rd);
        chk("ack", ack, 0);
        #20000;
        u_i2c_host_model.read(8'ha1, ack, rd);
        chk("ack", ack, 1);
        chk("fill", rd, FIELD_INFO_FILL);
        $display("bus done");
    endtask : t_bus
    initial begin
        faultIn.voutInReg = 1'b1;
        tick(5);
        rst_n = 1'b1;
        onReq_n = 1'b0;
        tick(SET);
        chk("main", mainEnable, 1);
        t_latches();
        t_overcurrent();
        t_temp_aux();
        t_warnings();
        t_bus();
        stop_test();
    end
endmodule : psu_fault_supervisor_test
